// *** core/flash_bus_pkg.sv ***
// shared constants and types for the flash bus read interface
package flash_bus_pkg;

    localparam int DATA_W            = 16;
    localparam int ADDR_W            = 22;
    localparam int PART_OFFSET_W     = 18;             // 4-Mbit partition of 16-bit words
    localparam int PART_W            = ADDR_W - PART_OFFSET_W;
    localparam int NUM_PARTS         = 1 << PART_W;
    localparam int FIRST_LATENCY_DEF = 3;              // bus clocks from capture to first word

    // command codes seen by the command_interface
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_IDENT  = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY  = 8'h98;

    // burst word counts
    localparam logic [4:0] BURST_WORDS_4  = 5'h04;
    localparam logic [4:0] BURST_WORDS_8  = 5'h08;
    localparam logic [4:0] BURST_WORDS_16 = 5'h10;

    // reset values
    localparam logic [3:0]        CTL_IDLE   = 4'hf;   // all control pins deasserted
    localparam logic [ADDR_W-1:0] ADDR_RESET = 22'h000000;

    typedef enum logic [1:0] {
        MODE_ARRAY,
        MODE_IDENT,
        MODE_QUERY,
        MODE_STATUS
    } read_mode_t;

    typedef enum logic [1:0] {
        BURST_4,
        BURST_8,
        BURST_16,
        BURST_CONT
    } burst_len_t;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_LATENCY,
        LINK_STREAM,
        LINK_DONE
    } link_state_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic address_valid_n;
    } bus_ctl_t;

    typedef struct packed {
        logic [7:0]        code;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_t;

endpackage

// *** core/flash_bus_read_interface.sv ***
// flash bus decode, per-partition read modes and synchronous burst sequencing
`timescale 1ns/1ps

// How it works
// - wait meaningful only in synchronous array reads
// - bursts of 4, 8, 16 or continuous
// - identifier mode returns id data, array hidden
// - query mode returns query table, array hidden
// - status mode returns partition status, array hidden
// - every partition in array mode bursts with internally stepped addresses
// - id, query, status reads single word, wait asserted
// - reset returns partitions to read-array mode; async or burst still set by sync_mode
// - reads need chip select; upper bits pick partition
// - address latch transparent while address valid
// - data driven only while output enable asserted
// - asynchronous mode captures address on valid release
// - synchronous capture: every clock with valid low, else valid rise
// - burst may suspend in latency or mid-stream
// - suspended burst keeps sensing, keeps latched data
// - suspend: selected, captured, clock stopped, output off
// - resume continues burst exactly where it stopped
// - wait gated by chip select, driven in suspend
// - write on write-enable rise, clock ignored
// - deselected device floats data outputs
// - reset floats data and wait outputs
module flash_bus_read_interface #(
    parameter int FIRST_LATENCY = flash_bus_pkg::FIRST_LATENCY_DEF
) (
    input  wire logic                                clk,             // core clock, 40 MHz
    input  wire logic                                reset_n,         // reset pin, active low
    input  wire logic                                bus_clk,         // flash bus burst clock
    input  wire logic                                ce_n,            // chip select, active low
    input  wire logic                                oe_n,            // output enable, active low
    input  wire logic                                we_n,            // write enable, active low
    input  wire logic                                address_valid_n, // address valid, low
    input  wire logic [flash_bus_pkg::ADDR_W-1:0]    addr,            // word address pins
    input  wire logic [flash_bus_pkg::DATA_W-1:0]    dq_in,           // data pins, input side
    output logic      [flash_bus_pkg::DATA_W-1:0]    dq_out,          // data pins, output side
    output logic                                     dq_oe,           // data pins driven
    output logic                                     wait_out,        // wait, high = not valid
    output logic                                     wait_oe,         // wait pin driven
    input  wire logic                                sync_mode,       // burst reads selected
    input  wire logic                                use_adv,         // async mode uses valid pin
    input  wire flash_bus_pkg::burst_len_t           burst_len,       // burst length setting
    output logic      [flash_bus_pkg::ADDR_W-1:0]    array_addr,      // array sense address
    input  wire logic [flash_bus_pkg::DATA_W-1:0]    array_data,      // array word at array_addr
    output logic [flash_bus_pkg::PART_OFFSET_W-1:0]  info_offset,     // offset within partition
    input  wire logic [flash_bus_pkg::DATA_W-1:0]    id_data,         // identifier word
    input  wire logic [7:0]                          query_data,      // query table byte
    input  wire logic [7:0]                          status_data,     // partition status byte
    output flash_bus_pkg::cmd_t                      cmd,             // command to the engine
    output logic                                     cmd_valid        // command strobe, one cycle
);
    import flash_bus_pkg::*;

    localparam int LAT_W = $clog2(FIRST_LATENCY + 1);

    // burst length setting to word count
    function automatic logic [4:0] burst_words(input burst_len_t len);
        logic [4:0] n;
        n = BURST_WORDS_16;
        unique case (len)
            BURST_4:    n = BURST_WORDS_4;
            BURST_8:    n = BURST_WORDS_8;
            BURST_16:   n = BURST_WORDS_16;
            BURST_CONT: n = BURST_WORDS_16;                        // count unused when continuous
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------------
    // core domain signals
    bus_ctl_t              ctl_s;
    bus_ctl_t              ctl_d;
    logic [ADDR_W-1:0]     addr_s;
    logic [DATA_W-1:0]     dq_s;
    logic                  we_rise;
    logic                  adv_rise;
    logic [ADDR_W-1:0]     latched_addr;
    logic                  adv_tgl;
    logic                  step_tgl_s;
    logic                  step_tgl_d;
    logic [ADDR_W-1:0]     burst_addr;
    logic                  burst_valid;
    read_mode_t            part_mode [NUM_PARTS];
    read_mode_t            lat_mode;
    read_mode_t            mode_q;
    logic [ADDR_W-1:0]     read_addr;

    // link domain signals
    logic [2:0]            link_cfg;
    logic                  link_sync;
    burst_len_t            link_len;
    logic                  adv_tgl_l;
    logic                  adv_tgl_ld;
    logic                  clk_loaded;
    logic                  pin_load;
    logic                  edge_load;
    link_state_t           link_state;
    logic [ADDR_W-1:0]     link_addr;
    logic                  link_ready;
    logic                  step_tgl;
    logic [4:0]            words_left;
    logic [LAT_W-1:0]      lat_cnt;

    // ------------------------------------------------------------------
    // pins into the core clock through two flops each
    sync2 #(.W(4), .RESET_VAL(CTL_IDLE)) u_ctl_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({ce_n, oe_n, we_n, address_valid_n}),
        .q       (ctl_s)
    );

    sync2 #(.W(ADDR_W)) u_addr_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (addr),
        .q       (addr_s)
    );

    sync2 #(.W(DATA_W)) u_dq_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (dq_in),
        .q       (dq_s)
    );

    // burst step events from the link clock
    sync2 #(.W(1)) u_step_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (step_tgl),
        .q       (step_tgl_s)
    );

    // previous control levels for edge detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_d <= CTL_IDLE;
        end else begin
            ctl_d <= ctl_s;
        end
    end

    // write ends on write-enable rise with chip select low, output enable high
    assign we_rise  = !ctl_d.we_n && ctl_s.we_n && !ctl_d.ce_n && ctl_d.oe_n;
    assign adv_rise = !ctl_d.address_valid_n && ctl_s.address_valid_n && !ctl_s.ce_n;

    // command capture handed to the program_erase_engine
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd       <= '0;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= we_rise;
            if (we_rise) begin
                cmd.code <= dq_s[7:0];
                cmd.addr <= addr_s;
                cmd.data <= dq_s;
            end
        end
    end

    // one mode register per partition, chosen by the upper address bits
    for (genvar p = 0; p < NUM_PARTS; p++) begin : g_part
        partition_mode u_mode (
            .clk     (clk),
            .reset_n (reset_n),
            .wr_stb  (we_rise && (addr_s[ADDR_W-1:PART_OFFSET_W] == PART_W'(p))),
            .code    (dq_s[7:0]),
            .mode    (part_mode[p])
        );
    end

    // address latch: open while valid is low, or always in async mode without use_adv; otherwise held after its release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latched_addr <= ADDR_RESET;
            adv_tgl      <= 1'b0;
        end else begin
            if ((!use_adv && !sync_mode) || !ctl_s.address_valid_n) begin
                latched_addr <= addr_s;
            end
            if (adv_rise && (use_adv || sync_mode)) begin
                adv_tgl <= !adv_tgl;
            end
        end
    end

    // take the burst address and readiness when the link reports a step
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            step_tgl_d  <= 1'b0;
            burst_addr  <= ADDR_RESET;
            burst_valid <= 1'b0;
        end else begin
            step_tgl_d <= step_tgl_s;
            if (step_tgl_s != step_tgl_d) begin
                burst_addr  <= link_addr;
                burst_valid <= link_ready;
            end
        end
    end

    // only array reads burst; other modes read the captured word
    assign lat_mode  = part_mode[latched_addr[ADDR_W-1:PART_OFFSET_W]];
    assign read_addr = (sync_mode && lat_mode == MODE_ARRAY) ? burst_addr
                                                              : latched_addr;

    // sense address kept up during suspend so sensing goes on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            array_addr  <= ADDR_RESET;
            info_offset <= '0;
            mode_q      <= MODE_ARRAY;
        end else begin
            array_addr  <= read_addr;
            info_offset <= read_addr[PART_OFFSET_W-1:0];
            mode_q      <= part_mode[read_addr[ADDR_W-1:PART_OFFSET_W]];
        end
    end

    // data word chosen by the partition's mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_out <= '0;
        end else begin
            unique case (mode_q)
                MODE_ARRAY:  dq_out <= array_data;
                MODE_IDENT:  dq_out <= id_data;
                MODE_QUERY:  dq_out <= {8'h00, query_data};
                MODE_STATUS: dq_out <= {8'h00, status_data};
            endcase
        end
    end

    // pin drivers; reset leaves both data and wait floating
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_oe    <= 1'b0;
            wait_oe  <= 1'b0;
            wait_out <= 1'b1;
        end else begin
            dq_oe    <= !ctl_s.ce_n && !ctl_s.oe_n && ctl_s.we_n;
            wait_oe  <= !ctl_s.ce_n;
            wait_out <= !(sync_mode && mode_q == MODE_ARRAY
                          && burst_valid && !ctl_s.oe_n);
        end
    end

    // ------------------------------------------------------------------
    // configuration and capture events into the link clock
    sync2 #(.W(3)) u_cfg_sync (
        .clk     (bus_clk),
        .reset_n (reset_n),
        .d       ({sync_mode, burst_len}),
        .q       (link_cfg)
    );

    sync2 #(.W(1)) u_adv_sync (
        .clk     (bus_clk),
        .reset_n (reset_n),
        .d       (adv_tgl),
        .q       (adv_tgl_l)
    );

    assign link_sync = link_cfg[2];
    assign link_len  = burst_len_t'(link_cfg[1:0]);

    // capture on a clock edge with valid low, else from the valid rise
    assign pin_load  = link_sync && !ce_n && !address_valid_n;
    assign edge_load = link_sync && !ce_n && address_valid_n
                       && (adv_tgl_l != adv_tgl_ld) && !clk_loaded;

    // remembers whether a clock edge already took this address
    always_ff @(posedge bus_clk or negedge reset_n) begin
        if (!reset_n) begin
            adv_tgl_ld <= 1'b0;
            clk_loaded <= 1'b0;
        end else begin
            adv_tgl_ld <= adv_tgl_l;
            if (pin_load) begin
                clk_loaded <= 1'b1;
            end else if (adv_tgl_l != adv_tgl_ld) begin
                clk_loaded <= 1'b0;
            end
        end
    end

    // burst sequencer; with output enable high it holds where it is
    always_ff @(posedge bus_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_state <= LINK_IDLE;
            link_addr  <= ADDR_RESET;
            link_ready <= 1'b0;
            step_tgl   <= 1'b0;
            words_left <= '0;
            lat_cnt    <= '0;
        end else if (ce_n || !link_sync) begin
            link_state <= LINK_IDLE;
            if (link_ready) begin
                link_ready <= 1'b0;
                step_tgl   <= !step_tgl;
            end
        end else if (pin_load || edge_load) begin
            link_addr  <= pin_load ? addr : latched_addr;
            words_left <= burst_words(link_len);
            lat_cnt    <= LAT_W'(FIRST_LATENCY);
            link_state <= LINK_LATENCY;
            link_ready <= 1'b0;
            step_tgl   <= !step_tgl;
        end else if (!oe_n) begin
            unique case (link_state)
                LINK_IDLE, LINK_DONE: begin
                    link_ready <= link_ready;
                end
                LINK_LATENCY: begin
                    if (lat_cnt <= LAT_W'(1)) begin
                        link_state <= LINK_STREAM;
                        link_ready <= 1'b1;
                        step_tgl   <= !step_tgl;
                    end else begin
                        lat_cnt <= lat_cnt - LAT_W'(1);
                    end
                end
                LINK_STREAM: begin
                    if (link_len == BURST_CONT || words_left > 5'h01) begin
                        link_addr  <= link_addr + ADDR_W'(1);
                        words_left <= words_left - 5'h01;
                        step_tgl   <= !step_tgl;
                    end else begin
                        link_state <= LINK_DONE;
                        link_ready <= 1'b0;
                        step_tgl   <= !step_tgl;
                    end
                end
            endcase
        end
    end
endmodule

// *** core/partition_mode.sv ***
// read mode register of one partition
`timescale 1ns/1ps
module partition_mode (
    input  wire logic                     clk,      // core clock
    input  wire logic                     reset_n,  // asynchronous reset, active low
    input  wire logic                     wr_stb,   // command written to this partition
    input  wire logic [7:0]               code,     // command code
    output flash_bus_pkg::read_mode_t     mode      // current read mode
);
    import flash_bus_pkg::*;

    // read commands pick the mode, others leave it alone
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= MODE_ARRAY;
        end else if (wr_stb) begin
            unique case (code)
                CMD_READ_ARRAY:  mode <= MODE_ARRAY;
                CMD_READ_IDENT:  mode <= MODE_IDENT;
                CMD_READ_QUERY:  mode <= MODE_QUERY;
                CMD_READ_STATUS: mode <= MODE_STATUS;
                default:         mode <= mode;
            endcase
        end
    end
endmodule

// *** core/sync2.sv ***
// two flip-flop synchroniser for a level or a held word
`timescale 1ns/1ps
module sync2 #(
    parameter int           W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         clk,      // destination clock
    input  wire logic         reset_n,  // asynchronous reset, active low
    input  wire logic [W-1:0] d,        // signal from the other domain
    output logic      [W-1:0] q         // synchronised copy
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// *** sim/flash_bus_read_interface_asserts.sv ***
// pin level checks for the flash bus read interface
`timescale 1ns/1ps
module flash_bus_asserts (
    input wire logic clk,       // core clock
    input wire logic reset_n,   // reset, active low
    input wire logic ce_n,      // chip select
    input wire logic oe_n,      // output enable
    input wire logic we_n,      // write enable
    input wire logic sync_mode, // burst reads selected
    input wire logic dq_oe,     // data pins driven
    input wire logic wait_out,  // wait level
    input wire logic wait_oe,   // wait pin driven
    input wire logic cmd_valid  // command strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // outputs float while reset is held
    chk_reset_float: assert property (disable iff (1'b0) !reset_n |-> !dq_oe && !wait_oe)
        else $error("outputs driven during reset");
    chk_desel_float: assert property (ce_n [*4] |-> !dq_oe && !wait_oe)
        else $error("pins driven while deselected");
    chk_oe_gate: assert property (oe_n [*4] |-> !dq_oe)
        else $error("data driven without output enable");
    chk_sel_wait: assert property (!ce_n [*4] |-> wait_oe)
        else $error("wait not driven while selected");
    chk_idle_wait: assert property ((!ce_n && oe_n && we_n) [*5] |-> wait_out && !dq_oe)
        else $error("selected idle bus wrong");
    chk_async_wait: assert property ((!sync_mode && !ce_n) [*6] |-> wait_out)
        else $error("wait released in asynchronous mode");
    chk_wait_sync: assert property (!wait_out && wait_oe |-> sync_mode)
        else $error("wait released outside burst mode");
    chk_write_cmd: assert property ($rose(we_n) && !ce_n && oe_n |-> ##[2:5] cmd_valid)
        else $error("write not taken");
    chk_write_gate: assert property ((ce_n || !oe_n) [*8] |-> !cmd_valid)
        else $error("command taken without a write cycle");

    // main scenarios reached
    cov_burst_word: cover property (!wait_out && dq_oe);
    cov_write: cover property (cmd_valid);
    cov_suspend: cover property (!ce_n && oe_n && sync_mode && wait_oe);
endmodule

bind flash_bus_read_interface flash_bus_asserts flash_bus_asserts_i (.clk, .reset_n, .ce_n,
    .oe_n, .we_n, .sync_mode, .dq_oe, .wait_out, .wait_oe, .cmd_valid);

// *** sim/flash_bus_read_interface_tb_top.sv ***
// self-checking bench for the flash bus read interface
`timescale 1ns/1ps
module flash_bus_read_interface_tb_top;
    import flash_bus_pkg::*;
    localparam int LIMIT = 20000; // cycle ceiling for the whole run
    logic clk, reset_n, bus_clk, ce_n, oe_n, we_n, address_valid_n;
    logic sync_mode, use_adv, dq_oe, wait_out, wait_oe, cmd_valid;
    burst_len_t burst_len;
    logic [ADDR_W-1:0] addr, array_addr;
    logic [DATA_W-1:0] dq_in, dq_out, array_data, id_data;
    logic [PART_OFFSET_W-1:0] info_offset;
    logic [7:0] query_data, status_data;
    cmd_t cmd;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;

    // array and info stores answer combinationally
    function automatic logic [DATA_W-1:0] word_at(input logic [ADDR_W-1:0] a);
        return a[15:0] ^ {a[21:18], 12'h5c3};
    endfunction
    assign array_data = word_at(array_addr);
    assign id_data = ~info_offset[15:0];
    assign query_data = info_offset[7:0] ^ 8'h3c;
    assign status_data = {4'h8, array_addr[21:18]};

    host_model host_model_i (.clk, .bus_clk, .ce_n, .oe_n, .we_n, .address_valid_n,
        .addr, .dq_in);
    flash_bus_read_interface flash_bus_read_interface_i (.clk, .reset_n, .bus_clk, .ce_n,
        .oe_n, .we_n, .address_valid_n, .addr, .dq_in, .dq_out, .dq_oe, .wait_out, .wait_oe,
        .sync_mode, .use_adv, .burst_len, .array_addr, .array_data, .info_offset, .id_data,
        .query_data, .status_data, .cmd, .cmd_valid);

    // core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic do_reset(input logic sm, input logic ua, input burst_len_t bl);
        @(negedge clk);
        reset_n = 1'b0;
        sync_mode = sm;
        use_adv = ua;
        burst_len = bl;
        repeat (20) @(negedge clk);
        check(wait_oe, 1'b0);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, b, input logic [DATA_W-1:0] exp);
        host_model_i.async_read(a, b);
        repeat (8) @(negedge clk);
        check(dq_out, exp);
        check(wait_out, 1'b1);
        host_model_i.idle();
        repeat (6) @(negedge clk);
        check(dq_oe, 1'b0);
    endtask

    task automatic t_async();
        do_reset(1'b0, 1'b1, BURST_4);
        rd(22'h0c0010, 22'h0c0020, word_at(22'h0c0010));
        do_reset(1'b0, 1'b0, BURST_4);
        rd(22'h0c0010, 22'h0c0020, word_at(22'h0c0020));
        $display("async reads done");
    endtask

    task automatic t_modes();
        logic [ADDR_W-1:0] pa, qa;
        logic [7:0] code [3];
        logic [DATA_W-1:0] exp [3];
        pa = 22'h0c0012;
        qa = 22'h140034;
        code = '{CMD_READ_IDENT, CMD_READ_QUERY, CMD_READ_STATUS};
        exp = '{~pa[15:0], {8'h00, pa[7:0] ^ 8'h3c}, {12'h008, pa[21:18]}};
        for (int i = 0; i < 3; i++) begin
            host_model_i.write_word(pa, code[i], 1'b0);
            rd(pa, pa, exp[i]);
            rd(qa, qa, word_at(qa));
        end
        host_model_i.write_word(pa, CMD_READ_ARRAY, 1'b0);
        rd(pa, pa, word_at(pa));
        host_model_i.write_word(pa, CMD_READ_STATUS, 1'b0);
        do_reset(1'b0, 1'b0, BURST_4);
        rd(pa, pa, word_at(pa));
        $display("read modes done");
    endtask

    task automatic t_write();
        host_model_i.write_word(22'h2abcde, CMD_READ_ARRAY, 1'b0);
        repeat (4) @(negedge clk);
        check(cmd.addr, 22'h2abcde);
        check(cmd.data, 16'h00ff);
        host_model_i.write_word(22'h000001, CMD_READ_STATUS, 1'b1);
        repeat (4) @(negedge clk);
        check(cmd.code, CMD_READ_ARRAY);
        $display("writes done");
    endtask

    task automatic susp();
        host_model_i.pause();
        repeat (10) @(negedge clk);
        check(wait_oe, 1'b1);
        check(wait_out, 1'b1);
        check(dq_oe, 1'b0);
        host_model_i.resume();
    endtask

    task automatic burst(input burst_len_t bl, input int n, input int pause_at,
                         input logic [ADDR_W-1:0] a, input logic [7:0] code);
        int k;
        k = 0;
        do_reset(1'b1, 1'b0, bl);
        host_model_i.write_word(a, code, 1'b0);
        host_model_i.burst_start(a, (pause_at < 0) ? 3 : 1);
        if (pause_at == 0)
            susp();
        for (int e = 0; e < 40; e++) begin
            @(posedge bus_clk);
            if (wait_out === 1'b0) begin
                check(dq_out, word_at(a + ADDR_W'(k)));
                k++;
                if (k == pause_at)
                    susp();
            end
        end
        if (bl != BURST_CONT)
            check(k, n);
        else
            check(k > n, 1'b1);
        host_model_i.idle();
        $display("burst of %0d words done", n);
    endtask

    // main sequence
    initial begin
        reset_n = 1'b0;
        sync_mode = 1'b0;
        use_adv = 1'b1;
        burst_len = BURST_4;
        t_async();
        t_modes();
        t_write();
        burst(BURST_4, 4, 0, 22'h0c0100, CMD_READ_ARRAY);
        burst(BURST_8, 8, 3, 22'h140200, CMD_READ_ARRAY);
        burst(BURST_16, 16, -1, 22'h0bfffa, CMD_READ_ARRAY);
        burst(BURST_CONT, 20, 10, 22'h300000, CMD_READ_ARRAY);
        burst(BURST_4, 0, -1, 22'h0c0100, CMD_READ_IDENT);
        tally_and_finish();
    end
endmodule

// *** sim/host_model.sv ***
// processor side of the flash bus: pin sequences and the burst clock
`timescale 1ns/1ps
module host_model (
    input  wire logic                    clk,             // core clock
    output logic                         bus_clk,         // burst clock, runs in frames only
    output logic                         ce_n,            // chip select
    output logic                         oe_n,            // output enable
    output logic                         we_n,            // write enable
    output logic                         address_valid_n, // address valid
    output logic [flash_bus_pkg::ADDR_W-1:0] addr,        // word address
    output logic [flash_bus_pkg::DATA_W-1:0] dq_in        // data on writes
);
    import flash_bus_pkg::*;
    logic run; // burst clock enable

    // pins idle, burst clock stopped, phase unrelated to the core clock
    initial begin
        {ce_n, oe_n, we_n, address_valid_n} = CTL_IDLE;
        addr = ADDR_RESET;
        dq_in = 16'h0000;
        run = 1'b0;
        bus_clk = 1'b0;
        #13;
        forever #80 if (run) bus_clk = ~bus_clk;
    end

    // all controls off, clock held, released data lines change
    task automatic idle();
        @(negedge clk);
        run = 1'b0;
        {ce_n, oe_n, we_n, address_valid_n} = CTL_IDLE;
        dq_in = ~dq_in;
    endtask

    // command write, address and data held across the rising write enable
    task automatic write_word(input logic [ADDR_W-1:0] a, input logic [7:0] code,
                              input logic oe);
        @(negedge clk);
        addr = a;
        dq_in = {8'h00, code};
        {ce_n, oe_n, we_n, address_valid_n} = {1'b0, ~oe, 2'b00};
        repeat (3) @(negedge clk);
        we_n = 1'b1;
        repeat (3) @(negedge clk);
        idle();
    endtask

    // asynchronous read: valid released on a, then pins move to b
    task automatic async_read(input logic [ADDR_W-1:0] a, b);
        @(negedge clk);
        addr = a;
        {ce_n, address_valid_n} = 2'b00;
        repeat (3) @(negedge clk);
        address_valid_n = 1'b1;
        @(negedge clk);
        addr = b;
        oe_n = 1'b0;
    endtask

    // burst start: valid held low over n clock edges, then pins move away
    task automatic burst_start(input logic [ADDR_W-1:0] a, input int n);
        @(negedge clk);
        addr = a;
        {ce_n, oe_n, address_valid_n} = 3'b000;
        run = 1'b1;
        repeat (n) @(posedge bus_clk);
        @(negedge clk);
        address_valid_n = 1'b1;
        addr = ~a;
    endtask

    // suspend holds the clock at its level, then drops output enable
    task automatic pause();
        run = 1'b0;
        @(negedge clk);
        oe_n = 1'b1;
    endtask

    task automatic resume();
        @(negedge clk);
        oe_n = 1'b0;
        repeat (6) @(negedge clk);
        run = 1'b1;
    endtask
endmodule
